/* core/cbi_addr_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module cbi_addr_decode (
  input wire logic [cbi_pkg::ADDR_W-1:0] i_addr,
  cbi_dec_if.dec sel
);
  import cbi_pkg::*;

  // ***************************************************************
  // Both address ranges decode to the same registers
  // ***************************************************************
  always_comb begin
    sel.sel_enable = cbi_hit(i_addr, CHAN_B_IRQ_ENABLE_OFF); // R15
    sel.sel_status = cbi_hit(i_addr, CHAN_B_IRQ_STATUS_OFF); // R16
    sel.sel_clear = cbi_hit(i_addr, CHAN_B_IRQ_STATUS_CLEAR_ON_READ_OFF); // R17
  end

endmodule : cbi_addr_decode
`default_nettype wire

/* core/cbi_top.sv */
// Overview of operation
// R1 - Enable bits 0-2: energy half-full interrupts
// R2 - Enable bits 3-5: energy overflow interrupts
// R3 - Enable bits 6-8: no-load interrupts
// R4 - Enable bits 9-10: sign change interrupts
// R5 - Enable bit 11: zero-cross timeout interrupt
// R6 - Enable bit 12: zero-cross interrupt
// R7 - Enable bit 13: overcurrent interrupt
// R8 - Status bits 0-2 set on half-full
// R9 - Status bits 3-5 set on overflow
// R10 - Status bits 6-8 set on no-load
// R11 - Status bits 9-10 set on sign change
// R12 - Status bit 11 set on zero-cross timeout
// R13 - Status bit 12 set on zero crossing
// R14 - Status bit 13 set on overcurrent
// R15 - Enable register at both mirror addresses
// R16 - Status register readable at both addresses
// R17 - Clear-on-read status view at both addresses
// R18 - Clear view read clears; plain read doesn't
// R19 - Low interrupt while any enabled status set
`timescale 1ns/1ps
`default_nettype none
module cbi_top (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [cbi_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [cbi_pkg::DATA_W-1:0] I_REG_WDATA,
  input wire logic [cbi_pkg::EVT_W-1:0] I_EVENTS,
  output logic [cbi_pkg::DATA_W-1:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  output logic O_IRQ_N
);
  import cbi_pkg::*;

  // ***************************************************************
  // Register state
  // ***************************************************************
  // Enables are kept per interrupt family, status per event
  logic [2:0] en_half_full;
  logic [2:0] en_overflow;
  logic [2:0] en_no_load;
  logic [1:0] en_sign_change;
  logic en_zero_cross_timeout;
  logic en_zero_cross;
  logic en_overcurrent;
  logic flag_active_energy_half_full;
  logic flag_reactive_energy_half_full;
  logic flag_apparent_energy_half_full;
  logic flag_active_energy_overflow;
  logic flag_reactive_energy_overflow;
  logic flag_apparent_energy_overflow;
  logic flag_active_power_no_load;
  logic flag_reactive_power_no_load;
  logic flag_apparent_power_no_load;
  logic flag_active_sign_change;
  logic flag_reactive_sign_change;
  logic flag_current_zero_cross_timeout;
  logic flag_current_zero_cross;
  logic flag_overcurrent_event;
  // Word views rebuilt from the registers above
  cbi_evt_t chan_b_irq_enable;
  cbi_evt_t chan_b_irq_status;
  cbi_evt_t next_enable;
  cbi_evt_t next_status;
  cbi_evt_t clear_mask;
  logic [DATA_W-1:0] next_rdata;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Next value of one sticky flag; a new event beats a same-cycle clear
  function automatic logic sticky_next(input logic cur, input logic clr, input logic evt);
    sticky_next = (cur & ~clr) | evt;
  endfunction : sticky_next

  cbi_dec_if dec ();

  cbi_addr_decode u_dec (
    .i_addr(I_REG_ADDR),
    .sel(dec.dec)
  );

  // ***************************************************************
  // Enable register
  // ***************************************************************
  // Bits above the event field are not stored and read back as zero
  always_comb begin
    next_enable = chan_b_irq_enable;
    if (I_REG_WR && dec.sel_enable) begin // R15
      next_enable = I_REG_WDATA[EVT_W-1:0];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_half_full <= CHAN_B_IRQ_ENABLE_RST[APPARENT_ENERGY_HALF_FULL:ACTIVE_ENERGY_HALF_FULL];
    end else begin
      en_half_full <= next_enable[APPARENT_ENERGY_HALF_FULL:ACTIVE_ENERGY_HALF_FULL]; // R1
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_overflow <= CHAN_B_IRQ_ENABLE_RST[APPARENT_ENERGY_OVERFLOW:ACTIVE_ENERGY_OVERFLOW];
    end else begin
      en_overflow <= next_enable[APPARENT_ENERGY_OVERFLOW:ACTIVE_ENERGY_OVERFLOW]; // R2
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_no_load <= CHAN_B_IRQ_ENABLE_RST[APPARENT_POWER_NO_LOAD:ACTIVE_POWER_NO_LOAD];
    end else begin
      en_no_load <= next_enable[APPARENT_POWER_NO_LOAD:ACTIVE_POWER_NO_LOAD]; // R3
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_sign_change <= CHAN_B_IRQ_ENABLE_RST[REACTIVE_SIGN_CHANGE:ACTIVE_SIGN_CHANGE];
    end else begin
      en_sign_change <= next_enable[REACTIVE_SIGN_CHANGE:ACTIVE_SIGN_CHANGE]; // R4
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_zero_cross_timeout <= CHAN_B_IRQ_ENABLE_RST[CURRENT_ZERO_CROSS_TIMEOUT];
    end else begin
      en_zero_cross_timeout <= next_enable[CURRENT_ZERO_CROSS_TIMEOUT]; // R5
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_zero_cross <= CHAN_B_IRQ_ENABLE_RST[CURRENT_ZERO_CROSS];
    end else begin
      en_zero_cross <= next_enable[CURRENT_ZERO_CROSS]; // R6
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_overcurrent <= CHAN_B_IRQ_ENABLE_RST[OVERCURRENT_EVENT];
    end else begin
      en_overcurrent <= next_enable[OVERCURRENT_EVENT]; // R7
    end
  end

  always_comb begin
    chan_b_irq_enable[APPARENT_ENERGY_HALF_FULL:ACTIVE_ENERGY_HALF_FULL] = en_half_full;
    chan_b_irq_enable[APPARENT_ENERGY_OVERFLOW:ACTIVE_ENERGY_OVERFLOW] = en_overflow;
    chan_b_irq_enable[APPARENT_POWER_NO_LOAD:ACTIVE_POWER_NO_LOAD] = en_no_load;
    chan_b_irq_enable[REACTIVE_SIGN_CHANGE:ACTIVE_SIGN_CHANGE] = en_sign_change;
    chan_b_irq_enable[CURRENT_ZERO_CROSS_TIMEOUT] = en_zero_cross_timeout;
    chan_b_irq_enable[CURRENT_ZERO_CROSS] = en_zero_cross;
    chan_b_irq_enable[OVERCURRENT_EVENT] = en_overcurrent;
  end

  // ***************************************************************
  // Status register
  // ***************************************************************
  // Event inputs are single-cycle pulses from the datapath on I_CLK,
  // so they need no synchroniser. Each event keeps a flag of its own;
  // a clear-view read drops only the bits it returned, and an event
  // landing in the same cycle as that read wins so it is never lost.
  // The word view below is rebuilt from the flags every cycle.
  always_comb begin
    clear_mask = '0;
    if (I_REG_RD && dec.sel_clear) begin // R18
      clear_mask = chan_b_irq_status;
    end
  end

  always_comb begin
    next_status = '0;
    for (int i = 0; i < EVT_W; i++) begin
      next_status[i] = sticky_next(chan_b_irq_status[i], clear_mask[i], I_EVENTS[i]);
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_active_energy_half_full <= CHAN_B_IRQ_STATUS_RST[ACTIVE_ENERGY_HALF_FULL];
    end else begin
      flag_active_energy_half_full <= next_status[ACTIVE_ENERGY_HALF_FULL]; // R8
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_reactive_energy_half_full <= CHAN_B_IRQ_STATUS_RST[REACTIVE_ENERGY_HALF_FULL];
    end else begin
      flag_reactive_energy_half_full <= next_status[REACTIVE_ENERGY_HALF_FULL]; // R8
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_apparent_energy_half_full <= CHAN_B_IRQ_STATUS_RST[APPARENT_ENERGY_HALF_FULL];
    end else begin
      flag_apparent_energy_half_full <= next_status[APPARENT_ENERGY_HALF_FULL]; // R8
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_active_energy_overflow <= CHAN_B_IRQ_STATUS_RST[ACTIVE_ENERGY_OVERFLOW];
    end else begin
      flag_active_energy_overflow <= next_status[ACTIVE_ENERGY_OVERFLOW]; // R9
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_reactive_energy_overflow <= CHAN_B_IRQ_STATUS_RST[REACTIVE_ENERGY_OVERFLOW];
    end else begin
      flag_reactive_energy_overflow <= next_status[REACTIVE_ENERGY_OVERFLOW]; // R9
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_apparent_energy_overflow <= CHAN_B_IRQ_STATUS_RST[APPARENT_ENERGY_OVERFLOW];
    end else begin
      flag_apparent_energy_overflow <= next_status[APPARENT_ENERGY_OVERFLOW]; // R9
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_active_power_no_load <= CHAN_B_IRQ_STATUS_RST[ACTIVE_POWER_NO_LOAD];
    end else begin
      flag_active_power_no_load <= next_status[ACTIVE_POWER_NO_LOAD]; // R10
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_reactive_power_no_load <= CHAN_B_IRQ_STATUS_RST[REACTIVE_POWER_NO_LOAD];
    end else begin
      flag_reactive_power_no_load <= next_status[REACTIVE_POWER_NO_LOAD]; // R10
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_apparent_power_no_load <= CHAN_B_IRQ_STATUS_RST[APPARENT_POWER_NO_LOAD];
    end else begin
      flag_apparent_power_no_load <= next_status[APPARENT_POWER_NO_LOAD]; // R10
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_active_sign_change <= CHAN_B_IRQ_STATUS_RST[ACTIVE_SIGN_CHANGE];
    end else begin
      flag_active_sign_change <= next_status[ACTIVE_SIGN_CHANGE]; // R11
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_reactive_sign_change <= CHAN_B_IRQ_STATUS_RST[REACTIVE_SIGN_CHANGE];
    end else begin
      flag_reactive_sign_change <= next_status[REACTIVE_SIGN_CHANGE]; // R11
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_current_zero_cross_timeout <= CHAN_B_IRQ_STATUS_RST[CURRENT_ZERO_CROSS_TIMEOUT];
    end else begin
      flag_current_zero_cross_timeout <= next_status[CURRENT_ZERO_CROSS_TIMEOUT]; // R12
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_current_zero_cross <= CHAN_B_IRQ_STATUS_RST[CURRENT_ZERO_CROSS];
    end else begin
      flag_current_zero_cross <= next_status[CURRENT_ZERO_CROSS]; // R13
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_overcurrent_event <= CHAN_B_IRQ_STATUS_RST[OVERCURRENT_EVENT];
    end else begin
      flag_overcurrent_event <= next_status[OVERCURRENT_EVENT]; // R14
    end
  end

  always_comb begin
    chan_b_irq_status[ACTIVE_ENERGY_HALF_FULL] = flag_active_energy_half_full;
    chan_b_irq_status[REACTIVE_ENERGY_HALF_FULL] = flag_reactive_energy_half_full;
    chan_b_irq_status[APPARENT_ENERGY_HALF_FULL] = flag_apparent_energy_half_full;
    chan_b_irq_status[ACTIVE_ENERGY_OVERFLOW] = flag_active_energy_overflow;
    chan_b_irq_status[REACTIVE_ENERGY_OVERFLOW] = flag_reactive_energy_overflow;
    chan_b_irq_status[APPARENT_ENERGY_OVERFLOW] = flag_apparent_energy_overflow;
    chan_b_irq_status[ACTIVE_POWER_NO_LOAD] = flag_active_power_no_load;
    chan_b_irq_status[REACTIVE_POWER_NO_LOAD] = flag_reactive_power_no_load;
    chan_b_irq_status[APPARENT_POWER_NO_LOAD] = flag_apparent_power_no_load;
    chan_b_irq_status[ACTIVE_SIGN_CHANGE] = flag_active_sign_change;
    chan_b_irq_status[REACTIVE_SIGN_CHANGE] = flag_reactive_sign_change;
    chan_b_irq_status[CURRENT_ZERO_CROSS_TIMEOUT] = flag_current_zero_cross_timeout;
    chan_b_irq_status[CURRENT_ZERO_CROSS] = flag_current_zero_cross;
    chan_b_irq_status[OVERCURRENT_EVENT] = flag_overcurrent_event;
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  // Reads return the value held before this cycle's events land;
  // unmapped addresses answer zero so the host never sees stale data.
  always_comb begin
    next_rdata = '0;
    if (dec.sel_enable) begin // R15
      next_rdata[EVT_W-1:0] = chan_b_irq_enable;
    end else if (dec.sel_status) begin // R16
      next_rdata[EVT_W-1:0] = chan_b_irq_status;
    end else if (dec.sel_clear) begin // R17
      next_rdata[EVT_W-1:0] = chan_b_irq_status;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_REG_RVALID <= 1'h0;
    end else begin
      O_REG_RVALID <= I_REG_RD; // R16
    end
  end

  // Held until the next read so a slow host may fetch it late
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_REG_RDATA <= '0;
    end else if (I_REG_RD) begin
      O_REG_RDATA <= next_rdata;
    end
  end

  // ***************************************************************
  // Interrupt output
  // ***************************************************************
  // Built from next values so the pin tracks the stored registers
  // in the same cycle rather than one cycle behind them.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_IRQ_N <= 1'h1;
    end else begin
      O_IRQ_N <= ~|(next_status & next_enable); // R1 R2 R3 R4 R5 R6 R7 R19
    end
  end

endmodule : cbi_top
`default_nettype wire

/* shared/cbi_dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cbi_dec_if;
  logic sel_enable;
  logic sel_status;
  logic sel_clear;
  modport dec (output sel_enable, output sel_status, output sel_clear);
  modport core (input sel_enable, input sel_status, input sel_clear);
endinterface : cbi_dec_if
`default_nettype wire

/* shared/cbi_pkg.sv */
package cbi_pkg;

  // ***************************************************************
  // Register map (word addresses of the device register space)
  // ***************************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int EVT_W = 14;
  localparam logic [ADDR_W-1:0] CHAN_B_IRQ_ENABLE_OFF = 10'h22F;
  localparam logic [ADDR_W-1:0] CHAN_B_IRQ_STATUS_OFF = 10'h230;
  localparam logic [ADDR_W-1:0] CHAN_B_IRQ_STATUS_CLEAR_ON_READ_OFF = 10'h231;
  // Second address range mirrors the first at this distance
  localparam logic [ADDR_W-1:0] MIRROR_STEP = 10'h100;

  localparam logic [EVT_W-1:0] CHAN_B_IRQ_ENABLE_RST = 14'h0000;
  localparam logic [EVT_W-1:0] CHAN_B_IRQ_STATUS_RST = 14'h0000;

  // ***************************************************************
  // Bit positions shared by enable and status registers
  // ***************************************************************
  localparam int ACTIVE_ENERGY_HALF_FULL = 0;
  localparam int REACTIVE_ENERGY_HALF_FULL = 1;
  localparam int APPARENT_ENERGY_HALF_FULL = 2;
  localparam int ACTIVE_ENERGY_OVERFLOW = 3;
  localparam int REACTIVE_ENERGY_OVERFLOW = 4;
  localparam int APPARENT_ENERGY_OVERFLOW = 5;
  localparam int ACTIVE_POWER_NO_LOAD = 6;
  localparam int REACTIVE_POWER_NO_LOAD = 7;
  localparam int APPARENT_POWER_NO_LOAD = 8;
  localparam int ACTIVE_SIGN_CHANGE = 9;
  localparam int REACTIVE_SIGN_CHANGE = 10;
  localparam int CURRENT_ZERO_CROSS_TIMEOUT = 11;
  localparam int CURRENT_ZERO_CROSS = 12;
  localparam int OVERCURRENT_EVENT = 13;

  typedef logic [EVT_W-1:0] cbi_evt_t;

  // True when addr hits a register at its base offset or its mirror
  function automatic logic cbi_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    cbi_hit = (addr == off) || (addr == off + MIRROR_STEP);
  endfunction : cbi_hit

endpackage : cbi_pkg

/* tb/cbi_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module cbi_checker (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [9:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [13:0] I_EVENTS,
  input wire logic [31:0] O_REG_RDATA,
  input wire logic O_REG_RVALID,
  input wire logic O_IRQ_N
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  sequence s_clr;
    I_REG_RD && (I_REG_ADDR == 10'h231 || I_REG_ADDR == 10'h331) && I_EVENTS == 14'h0;
  endsequence
  sequence s_stat;
    I_REG_RD && (I_REG_ADDR == 10'h230 || I_REG_ADDR == 10'h330) && I_EVENTS == 14'h0;
  endsequence
  a_rd_answer: assert property (I_REG_RD |=> O_REG_RVALID) else $error("no answer");
  a_no_answer: assert property (!I_REG_RD |=> !O_REG_RVALID) else $error("stray answer");
  a_rdata_hold: assert property (!O_REG_RVALID |-> $stable(O_REG_RDATA)) else $error("moved");
  a_upper_zero: assert property (O_REG_RVALID |-> O_REG_RDATA[31:14] == 18'h0)
    else $error("upper bits set");
  a_unmapped_zero: assert property (I_REG_RD && !(I_REG_ADDR inside {10'h22F, 10'h230,
    10'h231, 10'h32F, 10'h330, 10'h331}) |=> O_REG_RDATA == 32'h0) else $error("unmapped");
  a_irq_fall: assert property ($fell(O_IRQ_N) |-> $past(I_REG_WR) || $past(I_EVENTS) != 14'h0)
    else $error("irq without cause");
  a_irq_rise: assert property ($rose(O_IRQ_N) |-> $past(I_REG_WR) ||
    $past(I_REG_RD && (I_REG_ADDR == 10'h231 || I_REG_ADDR == 10'h331)))
    else $error("irq released early");
  a_clear_works: assert property (s_clr ##1 s_stat |=> O_REG_RDATA == 32'h0)
    else $error("not cleared");
  a_plain_keeps: assert property (s_stat ##1 s_stat |=> O_REG_RDATA == $past(O_REG_RDATA))
    else $error("plain read cleared");
endmodule : cbi_checker
`default_nettype wire

/* tb/cbi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cbi_host_model (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  output logic [9:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [31:0] o_wdata,
  output logic [13:0] o_ev
);
  initial begin
    {o_addr, o_wr, o_rd, o_wdata, o_ev} = '0;
  end
  // Strobes held by the next call, so back to back accesses never glitch
  task automatic write(input logic [9:0] a, input logic [31:0] d);
    {o_rd, o_wr, o_addr, o_wdata} = {1'h0, 1'h1, a, d};
    @(negedge i_clk);
  endtask : write
  task automatic read(input logic [9:0] a, output logic [31:0] d);
    {o_wr, o_rd, o_addr} = {1'h0, 1'h1, a};
    o_wdata = ~o_wdata;
    @(negedge i_clk);
    d = i_rdata;
  endtask : read
  task automatic pulse(input logic [13:0] e);
    {o_wr, o_rd, o_ev, o_addr, o_wdata} = {2'h0, e, ~o_addr, ~o_wdata};
    @(negedge i_clk);
    o_ev = 14'h0;
  endtask : pulse
endmodule : cbi_host_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cbi_pkg::*;
  logic clk, rst, wr, rd, rvalid, irq_n;
  logic [9:0] addr;
  logic [31:0] wdata, rdata;
  logic [13:0] ev;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  cbi_host_model h (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata), .o_ev(ev));
  cbi_top dut (.I_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd),
    .I_REG_WDATA(wdata), .I_EVENTS(ev), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .O_IRQ_N(irq_n));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] d;
    h.read(a, d);
    chk("rdata", e, d);
    chk("rvalid", 32'h1, rvalid);
  endtask : rdc
  task automatic give_verdict();
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    rst = 1'h1;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    rdc(10'h22F, 32'h0);
    rdc(10'h330, 32'h0);
    h.write(10'h32F, 32'hFFFFFFFF);
    rdc(10'h22F, 32'h3FFF);
    for (int n = 0; n < EVT_W; n++) begin
      h.pulse(14'h1 << n);
      chk("irq", 32'h0, irq_n);
      rdc(n % 2 ? 10'h330 : 10'h230, 32'h1 << n);
      rdc(n % 2 ? 10'h331 : 10'h231, 32'h1 << n);
      chk("irq", 32'h1, irq_n);
      rdc(10'h230, 32'h0);
    end
    h.write(10'h22F, 32'h0);
    h.pulse(14'h3FFF);
    chk("irq", 32'h1, irq_n);
    rdc(10'h330, 32'h3FFF);
    rdc(10'h230, 32'h3FFF);
    h.write(10'h32F, 32'h2000);
    chk("irq", 32'h0, irq_n);
    rdc(10'h331, 32'h3FFF);
    chk("irq", 32'h1, irq_n);
    rdc(10'h32F, 32'h2000);
    h.write(10'h230, 32'h5);
    rdc(10'h232, 32'h0);
    rdc(10'h230, 32'h0);
    give_verdict();
  end
endmodule : tb
bind cbi_top cbi_checker u_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_REG_ADDR(I_REG_ADDR),
  .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_EVENTS(I_EVENTS), .O_REG_RDATA(O_REG_RDATA),
  .O_REG_RVALID(O_REG_RVALID), .O_IRQ_N(O_IRQ_N));
`default_nettype wire
